// ===== rtl/motor_fault_supervisor.sv
// Motor fault supervisor with its AXI4-Lite register slave.
//
// The AXI4-Lite register port and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none
module motor_fault_supervisor
  import fault_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [AXI_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [AXI_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [2:0] drive_state,
  input wire logic config_done,
  input wire logic motor_gatekill_in,
  input wire logic pfc_gatekill_in,
  input wire logic crit_ov_cond,
  input wire logic ov_cond,
  input wire logic uv_cond,
  input wire logic overspeed_cond,
  input wire logic zero_speed_cond,
  input wire logic phase_loss_cond,
  input wire logic start_fail_cond,
  input wire logic cs_overspeed_cond,
  input wire logic converter_comp_fault,
  input wire logic internal_fault_request,
  input wire logic pwm_pulse,
  input wire logic cycle_done,
  output logic motor_stop,
  output logic pfc_stop,
  output logic fault_irq
);

  function automatic logic hit(input logic [AXI_ADDR_W-1:0] a,
                               input logic [AXI_ADDR_W-1:0] ofs);
    hit = (a[AXI_ADDR_W-1:2] == ofs[AXI_ADDR_W-1:2]);
  endfunction : hit

  function automatic logic mapped(input logic [AXI_ADDR_W-1:0] a);
    mapped = hit(a, OFS_FLAGS) | hit(a, OFS_MASK) | hit(a, OFS_CLEAR)
           | hit(a, OFS_INTREQ) | hit(a, OFS_STATUS);
  endfunction : mapped

  function automatic logic [FAULT_W-1:0] merge(input logic [FAULT_W-1:0] old,
                                               input logic [AXI_DATA_W-1:0] d,
                                               input logic [3:0] s);
    merge = old;
    if (s[0])
      merge[7:0] = d[7:0];
    if (s[1])
      merge[FAULT_W-1:8] = d[FAULT_W-1:8];
  endfunction : merge

  logic aw_hold_q, aw_hold_d;
  logic w_hold_q, w_hold_d;
  logic [AXI_ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [AXI_DATA_W-1:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [1:0] rresp_q, rresp_d;
  logic [AXI_DATA_W-1:0] rdata_q, rdata_d;
  logic [FAULT_W-1:0] mask_q, mask_d;
  logic intreq_q, intreq_d;
  logic cfg_done_q, cfg_done_d;
  logic busy_q, busy_d;
  logic exec_q, exec_d;
  logic [FAULT_W-1:0] latch_q, latch_d;
  logic [FAULT_W-1:0] flag_q, flag_d;
  logic irq_q, irq_d;

  wire take_aw;
  wire take_w;
  wire wr_fire;
  wire take_ar;
  wire [AXI_ADDR_W-1:0] wr_addr;
  wire [AXI_DATA_W-1:0] wr_data;
  wire [3:0] wr_strb;
  wire wr_mask;
  wire wr_intreq;
  wire clear_pulse;
  wire [AXI_DATA_W-1:0] status_word;
  wire [AXI_DATA_W-1:0] rd_word;
  wire [FAULT_W-1:0] armed;
  wire [FAULT_W-1:0] cond;
  wire [FAULT_W-1:0] raw;
  wire [FAULT_W-1:0] mask_eff;
  wire [FAULT_W-1:0] unmasked;

  // Write channel: address and data are taken in either order.
  assign s_axi_awready = ~aw_hold_q & ~bvalid_q;
  assign s_axi_wready = ~w_hold_q & ~bvalid_q;
  assign take_aw = s_axi_awvalid & s_axi_awready;
  assign take_w = s_axi_wvalid & s_axi_wready;
  assign wr_fire = (aw_hold_q | take_aw) & (w_hold_q | take_w);
  assign wr_addr = aw_hold_q ? awaddr_q : s_axi_awaddr;
  assign wr_data = w_hold_q ? wdata_q : s_axi_wdata;
  assign wr_strb = w_hold_q ? wstrb_q : s_axi_wstrb;
  assign wr_mask = wr_fire & hit(wr_addr, OFS_MASK);
  assign wr_intreq = wr_fire & hit(wr_addr, OFS_INTREQ) & wr_strb[0];
  assign clear_pulse = wr_fire & hit(wr_addr, OFS_CLEAR) & wr_strb[0] & wr_data[0];

  assign aw_hold_d = wr_fire ? 1'b0 : (aw_hold_q | take_aw);
  assign w_hold_d = wr_fire ? 1'b0 : (w_hold_q | take_w);
  assign awaddr_d = take_aw ? s_axi_awaddr : awaddr_q;
  assign wdata_d = take_w ? s_axi_wdata : wdata_q;
  assign wstrb_d = take_w ? s_axi_wstrb : wstrb_q;
  assign bvalid_d = wr_fire | (bvalid_q & ~s_axi_bready);
  assign bresp_d = wr_fire ? (mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR) : bresp_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // Read channel: data registered on the same edge that takes the address.
  assign s_axi_arready = ~rvalid_q;
  assign take_ar = s_axi_arvalid & s_axi_arready;
  assign status_word = {{(AXI_DATA_W - ST_STATE_LSB - 3){1'b0}}, drive_state,
                        1'b0, busy_q, cfg_done_q, motor_stop};
  assign rd_word = hit(s_axi_araddr, OFS_FLAGS) ? {{(AXI_DATA_W-FAULT_W){1'b0}}, flag_q} :
                   hit(s_axi_araddr, OFS_MASK) ? {{(AXI_DATA_W-FAULT_W){1'b0}}, mask_q} :
                   hit(s_axi_araddr, OFS_INTREQ) ? {{(AXI_DATA_W-1){1'b0}}, intreq_q} :
                   hit(s_axi_araddr, OFS_STATUS) ? status_word :
                   '0;
  assign rvalid_d = take_ar | (rvalid_q & ~s_axi_rready);
  assign rdata_d = take_ar ? rd_word : rdata_q;
  assign rresp_d = take_ar ? (mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR) : rresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // Software registers that steer the supervisor.
  assign mask_d = wr_mask ? merge(mask_q, wr_data, wr_strb) : mask_q;
  assign intreq_d = wr_intreq ? wr_data[0] : intreq_q;
  assign cfg_done_d = cfg_done_q | config_done;

  // Execution overrun: a new PWM pulse while the last cycle is unfinished.
  assign busy_d = pwm_pulse | (busy_q & ~cycle_done);
  assign exec_d = pwm_pulse & busy_q & ~cycle_done;

  fault_arm_table u_arm (
    .drive_state(drive_state),
    .init_stage(~cfg_done_q),
    .armed(armed)
  );

  assign cond[B_GATEKILL] = motor_gatekill_in;
  assign cond[B_CRIT_OV] = crit_ov_cond;
  assign cond[B_OV] = ov_cond;
  assign cond[B_UV] = uv_cond;
  assign cond[B_OVERSPD] = overspeed_cond;
  assign cond[B_ZEROSPD] = zero_speed_cond;
  assign cond[B_PHSLOSS] = phase_loss_cond;
  assign cond[B_STARTFAIL] = start_fail_cond;
  assign cond[B_INTERNAL] = internal_fault_request | intreq_q;
  assign cond[B_CS_OVERSPD] = cs_overspeed_cond;
  assign cond[B_EXEC] = exec_q;
  assign cond[B_PFC_GATEKILL] = pfc_gatekill_in;
  assign cond[B_CONV_COMP] = converter_comp_fault;

  assign raw = cond & armed;
  assign mask_eff = mask_q & ~NO_MASK;
  assign unmasked = raw & ~mask_eff;

  // Latches set per bit; a clear only drops bits whose cause is gone, set wins.
  assign latch_d = unmasked | (latch_q & ~({FAULT_W{clear_pulse}} & ~raw));
  assign flag_d = latch_d | (raw & mask_eff);
  assign irq_d = |(flag_d & ~flag_q);

  assign motor_stop = |latch_q;
  assign pfc_stop = |latch_q;
  assign fault_irq = irq_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      bvalid_q <= 1'b0;
      rvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rresp_q <= RESP_OKAY;
    end
    else
    begin
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      bvalid_q <= bvalid_d;
      rvalid_q <= rvalid_d;
      bresp_q <= bresp_d;
      rresp_q <= rresp_d;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      rdata_q <= '0;
    end
    else
    begin
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mask_q <= MASK_RST;
      intreq_q <= 1'b0;
      cfg_done_q <= 1'b0;
      busy_q <= 1'b0;
      exec_q <= 1'b0;
      latch_q <= FLAGS_RST;
      flag_q <= FLAGS_RST;
      irq_q <= 1'b0;
    end
    else
    begin
      mask_q <= mask_d;
      intreq_q <= intreq_d;
      cfg_done_q <= cfg_done_d;
      busy_q <= busy_d;
      exec_q <= exec_d;
      latch_q <= latch_d;
      flag_q <= flag_d;
      irq_q <= irq_d;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking

  default disable iff (!aresetn);

  // Gatekill always stops the drive, whatever the mask.
  AST_GATEKILL_STOPS: assert property (
    motor_gatekill_in |=> motor_stop && pfc_stop
  ) else $error("Motor gatekill did not stop the drive.");

  AST_CRIT_OV_STOPS: assert property (
    crit_ov_cond && mask_q[B_CRIT_OV] |=> motor_stop && flag_q[B_CRIT_OV]
  ) else $error("Critical overvoltage was masked.");

  AST_OVERSPD_ONLY_CLOSED: assert property (
    drive_state != 3'(DS_CLOSED_LOOP) && !flag_q[B_OVERSPD] |=> !flag_q[B_OVERSPD]
  ) else $error("Overspeed flagged outside closed loop.");

  AST_PHSLOSS_PARKING: assert property (
    phase_loss_cond && drive_state == 3'(DS_PARKING) && !mask_q[B_PHSLOSS]
    |=> flag_q[B_PHSLOSS] && motor_stop
  ) else $error("Phase loss during parking missed.");

  AST_COMP_AFTER_CONFIG: assert property (
    cfg_done_q && !flag_q[B_CONV_COMP] |=> !flag_q[B_CONV_COMP]
  ) else $error("Converter fault flagged after configuration.");

  AST_UNMASKED_OV_STOPS: assert property (
    ov_cond && !mask_q[B_OV] && !flag_q[B_OV] |=> motor_stop && pfc_stop ##0 fault_irq
  ) else $error("Unmasked overvoltage did not stop and interrupt.");

  AST_MASKED_RUNS: assert property (
    uv_cond && mask_q[B_UV] && !latch_q[B_UV] && !flag_q[B_UV]
    |=> flag_q[B_UV] && !latch_q[B_UV] && fault_irq
  ) else $error("Masked undervoltage handled wrongly.");

  AST_MASKED_FOLLOWS: assert property (
    !uv_cond && mask_q[B_UV] && !latch_q[B_UV] |=> !flag_q[B_UV]
  ) else $error("Masked flag did not drop with its condition.");

  AST_MULTI_FAULT: assert property (
    ov_cond && uv_cond |=> flag_q[B_OV] && flag_q[B_UV]
  ) else $error("Concurrent faults not both reported.");

  AST_CLEAR_NEEDS_GONE: assert property (
    clear_pulse && motor_gatekill_in |=> motor_stop
  ) else $error("Fault cleared while its cause remained.");

  AST_STOP_HOLDS: assert property (
    motor_stop && !clear_pulse |=> motor_stop
  ) else $error("Stop released without a clear.");

  AST_INTERNAL_REQ: assert property (
    internal_fault_request && !mask_q[B_INTERNAL] |=> flag_q[B_INTERNAL] && motor_stop
  ) else $error("Internal fault request ignored.");

  AST_EXEC_OVERRUN: assert property (
    pwm_pulse && busy_q && !cycle_done && !mask_q[B_EXEC] |=> ##1 flag_q[B_EXEC]
  ) else $error("Execution overrun not flagged.");

  AST_IRQ_ON_RISE: assert property (
    (flag_q & ~$past(flag_q)) != '0 |-> fault_irq
  ) else $error("Flag rose without an interrupt pulse.");

  AST_IRQ_CAUSE: assert property (
    fault_irq |-> (flag_q & ~$past(flag_q)) != '0
  ) else $error("Interrupt without a rising flag.");

  // Masked or unarmed conditions alone never stop a running drive.
  AST_MASKED_NO_STOP: assert property (
    !motor_stop && (cond & armed & ~mask_eff) == '0 |=> !motor_stop
  ) else $error("Drive stopped without an unmasked fault.");

  AST_CLEAR_RELEASES: assert property (
    clear_pulse && (cond & armed) == '0 |=> !motor_stop
  ) else $error("Clear with no cause left did not release the drive.");

endmodule : motor_fault_supervisor
`default_nettype wire

// ===== pkg/fault_pkg.sv
// Package with the constants and types of the motor fault supervisor.
package fault_pkg;

  localparam int FAULT_W = 13;
  localparam int AXI_ADDR_W = 8;
  localparam int AXI_DATA_W = 32;

  localparam logic [AXI_ADDR_W-1:0] OFS_FLAGS = 8'h00;
  localparam logic [AXI_ADDR_W-1:0] OFS_MASK = 8'h04;
  localparam logic [AXI_ADDR_W-1:0] OFS_CLEAR = 8'h08;
  localparam logic [AXI_ADDR_W-1:0] OFS_INTREQ = 8'h0C;
  localparam logic [AXI_ADDR_W-1:0] OFS_STATUS = 8'h10;

  localparam int B_GATEKILL = 0;
  localparam int B_CRIT_OV = 1;
  localparam int B_OV = 2;
  localparam int B_UV = 3;
  localparam int B_OVERSPD = 4;
  localparam int B_ZEROSPD = 5;
  localparam int B_PHSLOSS = 6;
  localparam int B_STARTFAIL = 7;
  localparam int B_INTERNAL = 8;
  localparam int B_CS_OVERSPD = 9;
  localparam int B_EXEC = 10;
  localparam int B_PFC_GATEKILL = 11;
  localparam int B_CONV_COMP = 12;

  localparam int ST_STOP_BIT = 0;
  localparam int ST_CFG_BIT = 1;
  localparam int ST_BUSY_BIT = 2;
  localparam int ST_STATE_LSB = 4;

  localparam logic [FAULT_W-1:0] ARM_ALWAYS = 13'h0D0F;
  localparam logic [FAULT_W-1:0] ARM_CLOSED = 13'h00B0;
  localparam logic [FAULT_W-1:0] ARM_PARKING = 13'h0040;
  localparam logic [FAULT_W-1:0] ARM_CATCH = 13'h0200;
  localparam logic [FAULT_W-1:0] ARM_INIT = 13'h1000;
  localparam logic [FAULT_W-1:0] NO_MASK = 13'h0803;

  localparam logic [FAULT_W-1:0] MASK_RST = 13'h0000;
  localparam logic [FAULT_W-1:0] FLAGS_RST = 13'h0000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    DS_STOPPED,
    DS_GATE_CHARGE,
    DS_PARKING,
    DS_STARTING,
    DS_CLOSED_LOOP,
    DS_CATCH_SPIN
  } drive_state_t;

endpackage : fault_pkg

// ===== rtl/fault_arm_table.sv
// Per drive state lookup of the armed fault checks.
`timescale 1ns/100ps
`default_nettype none
module fault_arm_table
  import fault_pkg::*;
(
  input wire logic [2:0] drive_state,
  input wire logic init_stage,
  output logic [FAULT_W-1:0] armed
);

  logic [FAULT_W-1:0] by_state;
  drive_state_t st;

  assign st = drive_state_t'(drive_state);

  always_comb
  begin
    unique case (st)
      DS_PARKING: by_state = ARM_ALWAYS | ARM_PARKING;
      DS_CLOSED_LOOP: by_state = ARM_ALWAYS | ARM_CLOSED;
      DS_CATCH_SPIN: by_state = ARM_ALWAYS | ARM_CATCH;
      DS_STOPPED, DS_GATE_CHARGE, DS_STARTING: by_state = ARM_ALWAYS;
      default: by_state = ARM_ALWAYS;
    endcase
  end

  // The converter compensation check only runs before the first configuration.
  assign armed = by_state | (init_stage ? ARM_INIT : '0);

endmodule : fault_arm_table
`default_nettype wire

// ===== verif/fault_host_model.sv
// Processor side model that counts fault interrupt pulses.
`timescale 1ns/100ps
`default_nettype none
module fault_host_model
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic fault_irq,
  output logic [15:0] irq_cnt
);
  // Counts interrupts and takes no action of its own on a masked fault.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_cnt <= 16'h0000;
    else if (fault_irq)
      irq_cnt <= irq_cnt + 16'h0001;
  end
endmodule : fault_host_model
`default_nettype wire

// ===== verif/motor_fault_supervisor_tb.sv
// Self-checking testbench of the motor fault supervisor.
`timescale 1ns/100ps
`default_nettype none
module motor_fault_supervisor_tb
  import fault_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, motor_stop, pfc_stop, fault_irq;
  logic [1:0] bresp, rresp;
  logic [1:0] pp = 2'h0;
  logic [2:0] st = 3'h0;
  logic cfg = 1'b0;
  logic [12:0] cnd = 13'h0000;
  logic [12:0] ng [3] = '{13'h0001, 13'h0002, 13'h0800};
  logic [15:0] irq_cnt, exp_irq = 16'h0000;
  int fails = 0;
  int tests_run = 0;

  initial forever #25 aclk = ~aclk;

  motor_fault_supervisor DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .drive_state(st), .config_done(cfg),
    .motor_gatekill_in(cnd[0]), .crit_ov_cond(cnd[1]), .ov_cond(cnd[2]), .uv_cond(cnd[3]),
    .overspeed_cond(cnd[4]), .zero_speed_cond(cnd[5]), .phase_loss_cond(cnd[6]),
    .start_fail_cond(cnd[7]), .internal_fault_request(cnd[8]),
    .cs_overspeed_cond(cnd[9]), .pfc_gatekill_in(cnd[11]), .converter_comp_fault(cnd[12]),
    .pwm_pulse(pp[0]), .cycle_done(pp[1]), .motor_stop(motor_stop), .pfc_stop(pfc_stop),
    .fault_irq(fault_irq));

  fault_host_model host (.aclk(aclk), .aresetn(aresetn), .fault_irq(fault_irq),
    .irq_cnt(irq_cnt));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t seen %h wanted %h", $time, got, exp);
    end
  endtask : chk

  task automatic tmo(input logic ok);
    if (ok !== 1'b1)
    begin
      fails++;
      stop_test();
    end
  endtask : tmo

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1 && n < 40);
    tmo(bvalid);
    chk(bresp, er);
    bready <= 1'b0;
    cyc(1);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er = RESP_OKAY);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (arready === 1'b1)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1 && n < 40);
    tmo(rvalid);
    chk(rdata, ed);
    chk(rresp, er);
    rready <= 1'b0;
    cyc(1);
  endtask : rd

  task automatic pls(input logic [1:0] v);
    pp <= v;
    cyc(1);
    pp <= 2'h0;
    cyc(1);
  endtask : pls

  function automatic logic [12:0] arm(input int s);
    return 13'h0D0F | (s == 4 ? 13'h00B0 : 13'h0000) | (s == 2 ? 13'h0040 : 13'h0000)
      | (s == 5 ? 13'h0200 : 13'h0000);
  endfunction : arm

  task automatic trip(input logic [12:0] c, input logic [12:0] ef, input logic es);
    cnd <= c;
    cyc(2);
    chk(fault_irq, |ef);
    chk(motor_stop, es);
    chk(pfc_stop, es);
    cyc(1);
    chk(fault_irq, 1'b0);
    if (|ef)
      exp_irq++;
    rd(OFS_FLAGS, ef);
    cnd <= 13'h0000;
    cyc(2);
    wr(OFS_CLEAR, 32'h1);
    rd(OFS_FLAGS, 32'h0);
    chk(motor_stop, 1'b0);
  endtask : trip

  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    cyc(1);
    chk(motor_stop, 1'b0);
    rd(OFS_FLAGS, 32'h0);
    rd(OFS_MASK, 32'h0);
    rd(8'h20, 32'h0, RESP_SLVERR);
    wr(8'h20, 32'h1, RESP_SLVERR);
    wr(OFS_FLAGS, 32'h1FFF);
    rd(OFS_FLAGS, 32'h0);
    trip(13'h1000, 13'h1000, 1'b1);
    cfg <= 1'b1;
    cyc(1);
    rd(OFS_STATUS, 32'h2);
    trip(13'h1000, 13'h0000, 1'b0);
    for (int s = 0; s < 6; s++)
    begin
      st <= 3'(s);
      cyc(1);
      for (int b = 0; b < 12; b++)
        if (b != B_EXEC)
          trip(13'h1 << b, arm(s) & (13'h1 << b), |(arm(s) & (13'h1 << b)));
    end
    st <= 3'h4;
    wr(OFS_MASK, 32'h1FFF);
    rd(OFS_MASK, 32'h1FFF);
    foreach (ng[i])
      trip(ng[i], ng[i], 1'b1);
    cnd <= 13'h000C;
    cyc(2);
    chk(fault_irq, 1'b1);
    exp_irq++;
    cyc(1);
    chk(motor_stop, 1'b0);
    rd(OFS_FLAGS, 32'hC);
    cnd <= 13'h0000;
    cyc(2);
    rd(OFS_FLAGS, 32'h0);
    wr(OFS_MASK, 32'h0);
    cnd <= 13'h0109;
    cyc(3);
    exp_irq++;
    wr(OFS_CLEAR, 32'h1);
    rd(OFS_FLAGS, 32'h109);
    chk(motor_stop, 1'b1);
    cnd <= 13'h0000;
    cyc(1);
    wr(OFS_CLEAR, 32'h1);
    rd(OFS_FLAGS, 32'h0);
    chk(motor_stop, 1'b0);
    wr(OFS_INTREQ, 32'h1);
    cyc(2);
    exp_irq++;
    rd(OFS_FLAGS, 32'h100);
    wr(OFS_INTREQ, 32'h0);
    rd(OFS_INTREQ, 32'h0);
    wr(OFS_CLEAR, 32'h1);
    rd(OFS_FLAGS, 32'h0);
    pls(2'h1);
    cyc(4);
    pls(2'h1);
    cyc(4);
    exp_irq++;
    rd(OFS_FLAGS, 32'h400);
    chk(motor_stop, 1'b1);
    pls(2'h2);
    wr(OFS_CLEAR, 32'h1);
    pls(2'h1);
    pls(2'h2);
    pls(2'h1);
    pls(2'h2);
    cyc(3);
    rd(OFS_FLAGS, 32'h0);
    chk(irq_cnt, exp_irq);
    stop_test();
  end
endmodule : motor_fault_supervisor_tb
`default_nettype wire
